/* File: hw/cks_defs.svh */
// Operation
// - aux divider source bit 13: 1 aux oscillator, 0 PLL VCO output.
// - aux oscillator mode: 11 external, 10 crystal, 01 high-speed, 00 off.
// - aux output divider codes 111..001 divide 1..64; 000 divides 256.
// - aux reference bit 7: 1 primary oscillator, 0 aux oscillator.
// - aux control bits 15:14 and 6:0 read zero, ignore writes.
// - switching and fail-safe monitor work only when switch config is 0.
// - switching off: new source stored and read back, status shows configured source.
// - switching off: switch request has no effect and stays zero.
// - request with new source equal to current is cleared, aborted.
// - valid switch start clears PLL lock and clock fail status.
// - start new oscillator; wait start-up timer or PLL lock.
// - count 10 new clock cycles before changing system clock.
// - completion clears request and copies new source into status.
// - stop old source except kept low-power RC or secondary oscillator.
// - processor keeps running during the switch sequence.
// - primary submode fixed by configuration, not changed by switching.
// - four sources switchable: primary, secondary, fast RC, low-power RC.
// - monitor enabled keeps low-power RC running continuously.
// - oscillator failure raises trap and falls back to fast RC.
// - failure while on PLL falls back to fast RC with PLL.
// - source codes 000 RC .. 111 RC divided by n, as listed; codes 110 and 111 are not defined here and run the fast RC undivided.
// - PLL lock status is 1 when locked, 0 otherwise or PLL off.
// - clock fail status is 1 once the monitor saw a failure.
`ifndef CKS_DEFS_SVH
`define CKS_DEFS_SVH
`define CKS_ADDR_W       4
`define CKS_OSC_ADDR     4'h0
`define CKS_AUX_ADDR     4'h1
`define CKS_SRC_FRC      3'h0
`define CKS_SRC_FAST_INTERNAL_RC_WITH_PLL   3'h1
`define CKS_SRC_PRI      3'h2
`define CKS_SRC_PRIPLL   3'h3
`define CKS_SRC_SEC      3'h4
`define CKS_SRC_LOW_POWER_INTERNAL_RC     3'h5
`define CKS_I_FRC        2'h0
`define CKS_I_PRI        2'h1
`define CKS_I_SEC        2'h2
`define CKS_I_LOW_POWER_INTERNAL_RC       2'h3
`define CKS_PIN_LOCK     4
`define CKS_PRI_EC       2'h0
`define CKS_CUR_HI       14
`define CKS_CUR_LO       12
`define CKS_NEW_HI       10
`define CKS_NEW_LO       8
`define CKS_LOCK_BIT     5
`define CKS_CF_BIT       3
`define CKS_SECEN_BIT    1
`define CKS_REQ_BIT      0
`define CKS_ASEL_BIT     13
`define CKS_AMODE_HI     12
`define CKS_AMODE_LO     11
`define CKS_ADIV_HI      10
`define CKS_ADIV_LO      8
`define CKS_AREF_BIT     7
`define CKS_ADIV_RESET   3'h0
`define CKS_NEW_CLK_WAIT 16'h000A
`define CKS_OST_EDGES    16'h0400
`define CKS_FAIL_EDGES   8'h04
`endif

/* File: hw/cks_pkg.sv */
`include "cks_defs.svh"
package cks_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_COUNT = 3'b010,
        ST_OFF   = 3'b011,
        ST_ON    = 3'b100
    } cks_state_t;

    typedef struct packed {
        logic       switch_enable_config;
        logic [2:0] initial_source_config;
        logic [1:0] primary_submode_config;
        logic       wdt_enable;
    } cks_cfg_t;

    typedef struct packed {
        logic       aux_divider_source_sel;
        logic [1:0] aux_osc_mode;
        logic       aux_osc_enable;
        logic [8:0] aux_divide_by;
        logic       aux_reference_sel;
    } cks_aux_t;

    typedef struct packed {
        logic [4:0]  s1;
        logic [4:0]  s2;
        logic [4:0]  s3;
        logic [4:0]  filt;
        logic        cfg_done;
        logic        sw_en;
        logic [1:0]  psub;
        cks_state_t  state;
        logic [2:0]  cur;
        logic [2:0]  new_source_sel;
        logic [2:0]  tgt;
        logic        switch_request;
        logic        lock;
        logic        clock_fail_flag;
        logic        secondary_osc_enable;
        logic [3:0]  osc_en;
        logic        pll_en;
        logic [3:0]  gate;
        logic [15:0] cnt;
        logic [7:0]  wd;
        logic        trap;
        logic [2:0]  adiv;
        cks_aux_t    aux;
        logic [15:0] rdata;
    } cks_regs_t;
endpackage : cks_pkg

/* File: hw/cks_clock_switch.sv */
`include "cks_defs.svh"
module cks_clock_switch #(
    parameter logic [15:0] OST_EDGES  = `CKS_OST_EDGES,
    parameter logic [7:0]  FAIL_EDGES = `CKS_FAIL_EDGES
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic [`CKS_ADDR_W-1:0] addr,
    input  wire logic [15:0]            wdata,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    output logic [15:0]                 rdata,
    input  wire cks_pkg::cks_cfg_t      cfg,
    input  wire logic [3:0]             osc_clk_pins,
    input  wire logic                   pll_lock_pin,
    output logic [2:0]                  sys_clk_sel,
    output logic [3:0]                  osc_enable,
    output logic                        pll_enable,
    output logic [3:0]                  clk_gate,
    output logic                        clk_fail_trap,
    output cks_pkg::cks_aux_t           aux
);
    import cks_pkg::*;

    cks_regs_t r;
    cks_regs_t next_r;
    logic [4:0] edge_seen;

    ////////////////////////////////////////////////////////////////////////
    // four oscillators behind the eight source codes
    function automatic logic [1:0] src_osc(input logic [2:0] code);
        case (code)
            `CKS_SRC_PRI, `CKS_SRC_PRIPLL: src_osc = `CKS_I_PRI;
            `CKS_SRC_SEC:                  src_osc = `CKS_I_SEC;
            `CKS_SRC_LOW_POWER_INTERNAL_RC:                 src_osc = `CKS_I_LOW_POWER_INTERNAL_RC;
            default:                       src_osc = `CKS_I_FRC;
        endcase
    endfunction : src_osc

    function automatic logic uses_pll(input logic [2:0] code);
        uses_pll = (code == `CKS_SRC_FAST_INTERNAL_RC_WITH_PLL) || (code == `CKS_SRC_PRIPLL);
    endfunction : uses_pll

    function automatic logic [8:0] div_of(input logic [2:0] code);
        case (code)
            3'h7:    div_of = 9'h001;
            3'h6:    div_of = 9'h002;
            3'h5:    div_of = 9'h004;
            3'h4:    div_of = 9'h008;
            3'h3:    div_of = 9'h010;
            3'h2:    div_of = 9'h020;
            3'h1:    div_of = 9'h040;
            default: div_of = 9'h100;
        endcase
    endfunction : div_of

    ////////////////////////////////////////////////////////////////////////
    // a pin change counts once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_pin
            assign edge_seen[gi] = (r.s2[gi] == r.s3[gi])
                                && (r.s3[gi] != r.filt[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  old_i;
    logic [1:0]  new_i;
    logic        new_edge;
    logic        mon_en;
    logic        need_ost;
    logic [15:0] rd;
    logic [3:0]  keep;

    always_comb begin
        next_r = r;
        next_r.trap = 1'b0;
        next_r.s1 = {pll_lock_pin, osc_clk_pins};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.filt = r.filt ^ edge_seen;
        old_i = src_osc(r.cur);
        new_i = src_osc(r.tgt);
        new_edge = edge_seen[new_i] && r.filt[new_i] == 1'b0;
        mon_en = r.sw_en;
        need_ost = (new_i == `CKS_I_SEC)
                || (new_i == `CKS_I_PRI && r.psub != `CKS_PRI_EC);
        keep = 4'h0;

        // configuration is static; captured once after reset release
        if (!r.cfg_done) begin
            next_r.cfg_done = 1'b1;
            next_r.sw_en = ~cfg.switch_enable_config;
            next_r.psub = cfg.primary_submode_config;
            next_r.cur = cfg.initial_source_config;
            next_r.new_source_sel = cfg.initial_source_config;
            next_r.tgt = cfg.initial_source_config;
            next_r.osc_en = 4'h0;
            next_r.osc_en[src_osc(cfg.initial_source_config)] = 1'b1;
            next_r.gate = 4'h0;
            next_r.gate[src_osc(cfg.initial_source_config)] = 1'b1;
            next_r.pll_en = uses_pll(cfg.initial_source_config);
        end

        // register port
        rd = 16'h0000;
        if (wr_en && addr == `CKS_OSC_ADDR) begin
            next_r.new_source_sel = wdata[`CKS_NEW_HI:`CKS_NEW_LO];
            next_r.secondary_osc_enable = wdata[`CKS_SECEN_BIT];
            if (wdata[`CKS_REQ_BIT] && r.sw_en && r.cfg_done
                && r.state == ST_IDLE) begin
                next_r.switch_request = 1'b1;
            end
        end
        if (wr_en && addr == `CKS_AUX_ADDR) begin
            next_r.aux.aux_divider_source_sel = wdata[`CKS_ASEL_BIT];
            next_r.aux.aux_osc_mode =
                wdata[`CKS_AMODE_HI:`CKS_AMODE_LO];
            next_r.aux.aux_osc_enable =
                wdata[`CKS_AMODE_HI:`CKS_AMODE_LO] != 2'h0;
            next_r.adiv = wdata[`CKS_ADIV_HI:`CKS_ADIV_LO];
            next_r.aux.aux_divide_by =
                div_of(wdata[`CKS_ADIV_HI:`CKS_ADIV_LO]);
            next_r.aux.aux_reference_sel = wdata[`CKS_AREF_BIT];
        end
        if (rd_en && addr == `CKS_OSC_ADDR) begin
            rd[`CKS_CUR_HI:`CKS_CUR_LO] = r.cur;
            rd[`CKS_NEW_HI:`CKS_NEW_LO] = r.new_source_sel;
            rd[`CKS_LOCK_BIT] = r.lock;
            rd[`CKS_CF_BIT] = r.clock_fail_flag;
            rd[`CKS_SECEN_BIT] = r.secondary_osc_enable;
            rd[`CKS_REQ_BIT] = r.switch_request;
        end
        if (rd_en && addr == `CKS_AUX_ADDR) begin
            rd[`CKS_ASEL_BIT] = r.aux.aux_divider_source_sel;
            rd[`CKS_AMODE_HI:`CKS_AMODE_LO] = r.aux.aux_osc_mode;
            rd[`CKS_ADIV_HI:`CKS_ADIV_LO] = r.adiv;
            rd[`CKS_AREF_BIT] = r.aux.aux_reference_sel;
        end
        next_r.rdata = rd;

        // lock status follows the filtered lock pin while the PLL runs
        next_r.lock = r.pll_en & r.filt[`CKS_PIN_LOCK];

        // switch sequence; the processor is never stalled by it
        case (r.state)
            ST_IDLE: begin
                if (r.switch_request) begin
                    if (r.new_source_sel == r.cur) begin
                        next_r.switch_request = 1'b0;
                    end else begin
                        next_r.tgt = r.new_source_sel;
                        next_r.lock = 1'b0;
                        next_r.clock_fail_flag = 1'b0;
                        next_r.osc_en[src_osc(r.new_source_sel)] = 1'b1;
                        next_r.pll_en = r.pll_en
                                      | uses_pll(r.new_source_sel);
                        next_r.cnt = 16'h0000;
                        next_r.state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // start-up timer only for crystals, lock only for the PLL
                if (need_ost && r.cnt < OST_EDGES) begin
                    if (new_edge) begin
                        next_r.cnt = r.cnt + 16'h0001;
                    end
                end else if (!uses_pll(r.tgt)
                             || r.filt[`CKS_PIN_LOCK]) begin
                    next_r.cnt = 16'h0000;
                    next_r.state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (r.cnt == `CKS_NEW_CLK_WAIT) begin
                    next_r.state = ST_OFF;
                end else if (new_edge) begin
                    next_r.cnt = r.cnt + 16'h0001;
                end
            end
            ST_OFF: begin
                // old gate drops only while the old clock is low
                if (!r.filt[old_i]) begin
                    next_r.gate = 4'h0;
                    next_r.state = ST_ON;
                end
            end
            ST_ON: begin
                if (!r.filt[new_i]) begin
                    next_r.gate[new_i] = 1'b1;
                    next_r.cur = r.tgt;
                    next_r.switch_request = 1'b0;
                    next_r.pll_en = uses_pll(r.tgt);
                    keep[new_i] = 1'b1;
                    keep[`CKS_I_LOW_POWER_INTERNAL_RC] = cfg.wdt_enable | mon_en;
                    keep[`CKS_I_SEC] = r.secondary_osc_enable;
                    if (!keep[old_i]) begin
                        next_r.osc_en[old_i] = 1'b0;
                    end
                    next_r.state = ST_IDLE;
                end
            end
            default: next_r.state = ST_IDLE;
        endcase

        // failure watchdog on low-power RC edges, cleared by clock edges
        if (!mon_en || edge_seen[old_i] || r.clock_fail_flag) begin
            next_r.wd = 8'h00;
        end else if (edge_seen[`CKS_I_LOW_POWER_INTERNAL_RC] && r.wd != FAIL_EDGES) begin
            next_r.wd = r.wd + 8'h01;
        end
        if (mon_en && r.wd == FAIL_EDGES && !r.clock_fail_flag) begin
            // failure wins over any switch in flight
            next_r.trap = 1'b1;
            next_r.clock_fail_flag = 1'b1;
            next_r.cur = uses_pll(r.cur) ? `CKS_SRC_FAST_INTERNAL_RC_WITH_PLL
                                         : `CKS_SRC_FRC;
            next_r.tgt = next_r.cur;
            next_r.osc_en[`CKS_I_FRC] = 1'b1;
            next_r.gate = 4'h0;
            next_r.gate[`CKS_I_FRC] = 1'b1;
            next_r.switch_request = 1'b0;
            next_r.state = ST_IDLE;
        end

        if (mon_en) begin
            next_r.osc_en[`CKS_I_LOW_POWER_INTERNAL_RC] = 1'b1;
        end
        if (r.secondary_osc_enable) begin
            next_r.osc_en[`CKS_I_SEC] = 1'b1;
        end
        if (!r.sw_en) begin
            next_r.switch_request = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.osc_en <= 4'h1;
            r.gate <= 4'h1;
            r.adiv <= `CKS_ADIV_RESET;
            r.aux.aux_divide_by <= 9'h100;
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign sys_clk_sel = r.cur;
    assign osc_enable = r.osc_en;
    assign pll_enable = r.pll_en;
    assign clk_gate = r.gate;
    assign clk_fail_trap = r.trap;
    assign aux = r.aux;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_start;
        r.state == ST_IDLE ##1 r.state == ST_WAIT;
    endsequence
    sequence s_done;
        r.state == ST_ON ##1 r.state == ST_IDLE;
    endsequence

    redundant_abort_a: assert property (
        r.state == ST_IDLE && r.switch_request && r.cfg_done
        && r.new_source_sel == r.cur && r.wd != FAIL_EDGES
        |=> !r.switch_request && r.state == ST_IDLE)
        else $error("redundant request not aborted");
    start_clears_a: assert property (
        s_start |-> !r.lock && !r.clock_fail_flag)
        else $error("switch start left status set");
    ten_edges_a: assert property (
        r.state == ST_COUNT ##1 r.state == ST_OFF
        |-> $past(r.cnt) == `CKS_NEW_CLK_WAIT)
        else $error("changeover before ten new clock cycles");
    done_update_a: assert property (
        s_done |-> r.cur == r.tgt && !r.switch_request
                   && $onehot(r.gate))
        else $error("completion did not update status");
    sw_off_req_a: assert property (
        r.cfg_done && !r.sw_en |=> !r.switch_request)
        else $error("request set while switching disabled");
    fail_back_a: assert property (
        r.sw_en && r.wd == FAIL_EDGES && !r.clock_fail_flag
        |=> r.trap && r.clock_fail_flag && r.gate[`CKS_I_FRC]
            && (r.cur == `CKS_SRC_FRC || r.cur == `CKS_SRC_FAST_INTERNAL_RC_WITH_PLL))
        else $error("failure did not fall back to fast RC");
    fail_pll_a: assert property (
        r.sw_en && r.wd == FAIL_EDGES && !r.clock_fail_flag
        && uses_pll(r.cur) |=> r.cur == `CKS_SRC_FAST_INTERNAL_RC_WITH_PLL)
        else $error("PLL lost on failure fallback");
    low_power_internal_rc_on_a: assert property (
        r.cfg_done && r.sw_en |=> r.osc_en[`CKS_I_LOW_POWER_INTERNAL_RC])
        else $error("low-power RC stopped under monitor");
    aux_zero_a: assert property (
        rd_en && addr == `CKS_AUX_ADDR
        |=> rdata[15:14] == 2'h0 && rdata[6:0] == 7'h00)
        else $error("aux reserved bits not zero");
    gate_one_a: assert property (
        $onehot0(r.gate))
        else $error("two clock gates open at once");
endmodule : cks_clock_switch

/* File: verification/cks_clock_switch_bench.sv */
`include "cks_defs.svh"
module cks_clock_switch_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cks_pkg::*;

    logic              clock;
    logic              rst_n        = 1'b0;
    logic [3:0]        addr         = 4'h0;
    logic [15:0]       wdata        = 16'h0000;
    logic              wr_en        = 1'b0;
    logic              rd_en        = 1'b0;
    logic [15:0]       rdata;
    cks_cfg_t          cfg          = '{1'b0, 3'h0, 2'h1, 1'b0};
    logic [3:0]        osc_clk_pins = 4'h0;
    logic [3:0]        osc_run      = 4'hF;
    logic              pll_lock_pin = 1'b0;
    logic [2:0]        sys_clk_sel;
    logic [3:0]        osc_enable;
    logic              pll_enable;
    logic [3:0]        clk_gate;
    logic              clk_fail_trap;
    cks_aux_t          aux;
    logic [15:0]       exp_q[$];
    logic              rd_seen      = 1'b0;
    logic [7:0]        cyc          = 8'h00;
    int                failures     = 0;
    int                total_checks = 0;
    logic [15:0]       d;
    logic              trap_seen;

    // short start-up and failure counts keep the run brief
    cks_clock_switch #(.OST_EDGES(16'h0004), .FAIL_EDGES(8'h03)) dut_u (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cfg(cfg),
        .osc_clk_pins(osc_clk_pins), .pll_lock_pin(pll_lock_pin),
        .sys_clk_sel(sys_clk_sel), .osc_enable(osc_enable),
        .pll_enable(pll_enable), .clk_gate(clk_gate),
        .clk_fail_trap(clk_fail_trap), .aux(aux));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillators: each pin has its own slow period; a stopped one freezes
    always @(posedge clock) begin
        cyc <= cyc + 8'h01;
        for (int i = 0; i < 4; i++) begin
            if (osc_run[i] && (cyc % (i + 2) == 0)) begin
                osc_clk_pins[i] <= ~osc_clk_pins[i];
            end
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        rd_seen <= rd_en;
        if (rd_seen) begin
            check(rdata, exp_q.pop_front());
        end
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        exp_q.push_back(exp);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(posedge clock);
    endtask : rd

    task automatic wait_src(input logic [2:0] exp);
        int n;
        n = 0;
        while (sys_clk_sel !== exp && n < 400) begin
            @(posedge clock);
            n++;
        end
        check(16'(sys_clk_sel), 16'(exp));
    endtask : wait_src

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask : do_reset

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(15));
        do_reset();
        check(16'(aux.aux_divide_by), 16'h0100);
        check(16'(clk_gate), 16'h0001);
        rd(`CKS_AUX_ADDR, 16'h0000);
        rd(`CKS_OSC_ADDR, 16'h0000);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            d = 16'($urandom);
            d[10:8] = 3'(c);
            d[12:11] = 2'(c);
            wr(`CKS_AUX_ADDR, d);
            rd(`CKS_AUX_ADDR, d & 16'h3F80);
            check(16'(aux), 16'({d[13], d[12:11], d[12:11] != 2'h0,
                (c == 0) ? 9'h100 : 9'(1 << (7 - c)), d[7]}));
        end
        wr(4'h5, 16'hFFFF);
        rd(4'h5, 16'h0000);
        $display("test aux register done");
        wr(`CKS_OSC_ADDR, 16'h0000);
        wr(`CKS_OSC_ADDR, 16'h0001);
        rd(`CKS_OSC_ADDR, 16'h0000);
        $display("test redundant switch done");
        wr(`CKS_OSC_ADDR, 16'h0500);
        wr(`CKS_OSC_ADDR, 16'h0501);
        rd(`CKS_OSC_ADDR, 16'h0501);
        wait_src(3'h5);
        rd(`CKS_OSC_ADDR, 16'h5500);
        check(16'(osc_enable), 16'h0008);
        check(16'(clk_gate), 16'h0008);
        $display("test switch to low-power rc done");
        wr(`CKS_OSC_ADDR, 16'h0300);
        wr(`CKS_OSC_ADDR, 16'h0301);
        repeat (60) @(posedge clock);
        check(16'(sys_clk_sel), 16'h0005);
        rd(`CKS_OSC_ADDR, 16'h5301);
        pll_lock_pin <= 1'b1;
        wait_src(3'h3);
        rd(`CKS_OSC_ADDR, 16'h3320);
        check(16'(osc_enable), 16'h000A);
        check(16'(pll_enable), 16'h0001);
        $display("test switch to primary with pll done");
        osc_run[1] <= 1'b0;
        trap_seen = 1'b0;
        for (int n = 0; n < 300 && !trap_seen; n++) begin
            @(posedge clock);
            trap_seen = clk_fail_trap;
        end
        check(16'(trap_seen), 16'h0001);
        wait_src(3'h1);
        rd(`CKS_OSC_ADDR, 16'h1328);
        check(16'(clk_gate), 16'h0001);
        $display("test clock failure done");
        // leave the pll mode through plain fast rc, never pll to pll
        wr(`CKS_OSC_ADDR, 16'h0000);
        wr(`CKS_OSC_ADDR, 16'h0001);
        wait_src(3'h0);
        rd(`CKS_OSC_ADDR, 16'h0000);
        wr(`CKS_OSC_ADDR, 16'h0002);
        rd(`CKS_OSC_ADDR, 16'h0002);
        check(16'(osc_enable[2]), 16'h0001);
        $display("test recovery done");
        osc_run[1] <= 1'b1;
        cfg <= '{1'b1, 3'h2, 2'h1, 1'b0};
        do_reset();
        rd(`CKS_OSC_ADDR, 16'h2200);
        wr(`CKS_OSC_ADDR, 16'h0501);
        rd(`CKS_OSC_ADDR, 16'h2500);
        repeat (60) @(posedge clock);
        check(16'(sys_clk_sel), 16'h0002);
        check(16'(clk_fail_trap), 16'h0000);
        $display("test switching disabled done");
        results();
    end
endmodule : cks_clock_switch_bench
